// ==== common/extirq_pkg.sv ====
// package for the external pin interrupt latch: constants and carrier types
package extirq_pkg;

    // ==========================================================
    // synchroniser and reset values
    localparam int EXTIRQ_SYNC_STAGES = 2;
    localparam logic EXTIRQ_PIN_IDLE = 1'h1;
    localparam logic EXTIRQ_MASK_RESET = 1'h0;
    localparam logic EXTIRQ_MODE_RESET = 1'h0;
    localparam logic EXTIRQ_LATCH_RESET = 1'h0;

    // ==========================================================
    // trigger sensitivity
    localparam logic EXTIRQ_MODE_EDGE = 1'h0;
    localparam logic EXTIRQ_MODE_EDGE_LEVEL = 1'h1;

    // ==========================================================
    // vector location served for this request
    localparam logic [15:0] EXTIRQ_VECTOR_HI_ADDR = 16'hFFFA;
    localparam logic [15:0] EXTIRQ_VECTOR_LO_ADDR = 16'hFFFB;

    // ==========================================================
    // status and control register bit positions
    localparam int EXTIRQ_BIT_MODE = 0;
    localparam int EXTIRQ_BIT_MASK = 1;
    localparam int EXTIRQ_BIT_ACK = 2;
    localparam int EXTIRQ_BIT_PEND = 3;

    // software write to the status/control register
    typedef struct packed {
        logic write;
        logic ack;
        logic request_mask_bit;
        logic mode;
    } extirq_ctrl_wr_type;

    // readable view of the status/control register
    typedef struct packed {
        logic pending_flag;
        logic ack;
        logic request_mask_bit;
        logic mode;
    } extirq_status_type;

endpackage : extirq_pkg

// ==== rtl/extirq_latch.sv ====
// external pin interrupt latch with edge or edge-plus-level trigger
`timescale 1ns/10ps
module extirq_latch
    import extirq_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic reset,
    // external pin, active low
    input wire logic irq_pin_n,
    // software access to the status/control register
    input wire extirq_ctrl_wr_type ctrl_wr,
    output extirq_status_type ext_int_status_control_reg,
    // cpu side
    input wire logic condition_code_mask,
    input wire logic vector_fetch,
    output logic irq_request,
    output logic [15:0] vector_hi_addr,
    output logic [15:0] vector_lo_addr,
    output logic branch_if_pin_high,
    output logic branch_if_pin_low
);

    // ==========================================================
    // pin synchroniser
    logic [EXTIRQ_SYNC_STAGES-1:0] pin_sync;
    logic pin_level;

    // no reset on the chain: it tracks the pin through reset, so a pin
    // held low across reset shows no false edge once reset ends
    generate
        for (genvar stage = 0; stage < EXTIRQ_SYNC_STAGES; stage++) begin : g_sync
            if (stage == 0) begin : g_first
                always_ff @(posedge clk) begin
                    pin_sync[stage] <= irq_pin_n;
                end
            end else begin : g_next
                always_ff @(posedge clk) begin
                    pin_sync[stage] <= pin_sync[stage-1];
                end
            end
        end
    endgenerate

    assign pin_level = pin_sync[EXTIRQ_SYNC_STAGES-1];

    // ==========================================================
    // edge and level detect
    logic pin_prev;
    logic falling_edge;
    logic low_level;

    // follows the synchronised level, reset or not, for the same reason
    always_ff @(posedge clk) begin
        pin_prev <= pin_level;
    end

    assign falling_edge = pin_prev & ~pin_level;
    assign low_level = ~pin_level;

    // ==========================================================
    // control bits
    logic request_mask_bit;
    logic mode;
    logic next_request_mask_bit;
    logic next_mode;

    // value in force at this edge, a write in this cycle included
    always_comb begin
        next_request_mask_bit = request_mask_bit;
        if (ctrl_wr.write) begin
            next_request_mask_bit = ctrl_wr.request_mask_bit;
        end
    end

    always_comb begin
        next_mode = mode;
        if (ctrl_wr.write) begin
            next_mode = ctrl_wr.mode;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            request_mask_bit <= EXTIRQ_MASK_RESET;
        end else begin
            request_mask_bit <= next_request_mask_bit;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            mode <= EXTIRQ_MODE_RESET;
        end else begin
            mode <= next_mode;
        end
    end

    // ==========================================================
    // acknowledge sources
    logic fetch_ack;
    logic soft_ack;
    logic ack;

    // vector fetch only acknowledges the request it was raised for
    assign fetch_ack = vector_fetch & irq_request;
    assign soft_ack = ctrl_wr.write & ctrl_wr.ack;
    assign ack = fetch_ack | soft_ack;

    // ==========================================================
    // acknowledge remembered while the pin is still low
    logic ack_seen;
    logic next_ack_seen;
    logic latch;
    logic next_latch;

    // edge-plus-level mode needs ack and a high pin in either order;
    // a new edge after the ack starts a request of its own
    always_comb begin
        next_ack_seen = ack_seen;
        if (ack) begin
            next_ack_seen = 1'h1;
        end
        if (falling_edge) begin
            next_ack_seen = 1'h0;
        end
        if (!next_latch || mode == EXTIRQ_MODE_EDGE) begin
            next_ack_seen = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ack_seen <= EXTIRQ_LATCH_RESET;
        end else begin
            ack_seen <= next_ack_seen;
        end
    end

    // ==========================================================
    // request latch
    logic set_req;
    logic clear_req;

    // edge sets in both modes, a low level only in edge-plus-level mode
    assign set_req = falling_edge | (mode == EXTIRQ_MODE_EDGE_LEVEL && low_level);

    always_comb begin
        clear_req = 1'h0;
        unique case (mode)
            EXTIRQ_MODE_EDGE: begin
                clear_req = ack;
            end
            EXTIRQ_MODE_EDGE_LEVEL: begin
                clear_req = (ack | ack_seen) & pin_level;
            end
        endcase
    end

    // a set in the same cycle as a clear wins
    always_comb begin
        next_latch = latch;
        if (clear_req) begin
            next_latch = 1'h0;
        end
        if (set_req) begin
            next_latch = 1'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            latch <= EXTIRQ_LATCH_RESET;
        end else begin
            latch <= next_latch;
        end
    end

    // ==========================================================
    // request to the priority logic
    logic forward_en;

    // both masks act on the value in force at this edge
    assign forward_en = ~next_request_mask_bit & ~condition_code_mask;

    always_ff @(posedge clk) begin
        if (reset) begin
            irq_request <= EXTIRQ_LATCH_RESET;
        end else begin
            irq_request <= next_latch & forward_en;
        end
    end

    // ==========================================================
    // status and control readback
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_int_status_control_reg.pending_flag <= EXTIRQ_LATCH_RESET;
        end else begin
            ext_int_status_control_reg.pending_flag <= next_latch;
        end
    end

    // acknowledge is write-only
    always_ff @(posedge clk) begin
        if (reset) begin
            ext_int_status_control_reg.ack <= 1'h0;
        end else begin
            ext_int_status_control_reg.ack <= 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ext_int_status_control_reg.request_mask_bit <= EXTIRQ_MASK_RESET;
        end else begin
            ext_int_status_control_reg.request_mask_bit <= next_request_mask_bit;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ext_int_status_control_reg.mode <= EXTIRQ_MODE_RESET;
        end else begin
            ext_int_status_control_reg.mode <= next_mode;
        end
    end

    // ==========================================================
    // vector location for the cpu
    always_ff @(posedge clk) begin
        if (reset) begin
            vector_hi_addr <= EXTIRQ_VECTOR_HI_ADDR;
        end else begin
            vector_hi_addr <= EXTIRQ_VECTOR_HI_ADDR;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            vector_lo_addr <= EXTIRQ_VECTOR_LO_ADDR;
        end else begin
            vector_lo_addr <= EXTIRQ_VECTOR_LO_ADDR;
        end
    end

    // ==========================================================
    // pin level for the branch conditions
    always_ff @(posedge clk) begin
        if (reset) begin
            branch_if_pin_high <= EXTIRQ_PIN_IDLE;
        end else begin
            branch_if_pin_high <= pin_level;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            branch_if_pin_low <= ~EXTIRQ_PIN_IDLE;
        end else begin
            branch_if_pin_low <= ~pin_level;
        end
    end

    // ==========================================================
    // limitations
    // the pin is seen two edges late through the synchroniser, and a low
    // pulse shorter than one clock period may fall between edges and be missed
    // in edge-plus-level mode a request raised by a low level that ends
    // before any ack still waits for an ack, as an edge request does

endmodule : extirq_latch

// ==== sim/extirq_latch_assertions.sv ====
// concurrent checks on the external pin interrupt latch ports
`timescale 1ns/10ps
module extirq_latch_assertions
    import extirq_pkg::*;
(
    // watched ports
    input wire logic clk,
    input wire logic reset,
    input wire logic irq_pin_n,
    input wire extirq_ctrl_wr_type ctrl_wr,
    input wire extirq_status_type ext_int_status_control_reg,
    input wire logic condition_code_mask,
    input wire logic vector_fetch,
    input wire logic irq_request,
    input wire logic [15:0] vector_hi_addr,
    input wire logic [15:0] vector_lo_addr,
    input wire logic branch_if_pin_high,
    input wire logic branch_if_pin_low
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire extirq_status_type st = ext_int_status_control_reg;
    sequence s_high; irq_pin_n[*5]; endsequence
    sequence s_ack;
        (vector_fetch && irq_request && !ctrl_wr.write)
            || (ctrl_wr.write && ctrl_wr.ack && !ctrl_wr.mode);
    endsequence
    a_ack_zero: assert property (!st.ack) else $error("ack reads one");
    a_request_gate: assert property (irq_request == (st.pending_flag
        && !st.request_mask_bit && !$past(condition_code_mask))) else $error("bad gating");
    a_pin_inverse: assert property (branch_if_pin_high != branch_if_pin_low)
        else $error("pin views agree");
    a_pin_level: assert property ($stable(irq_pin_n)[*5] |-> branch_if_pin_high == irq_pin_n)
        else $error("pin level");
    a_fall_sets: assert property ($fell(irq_pin_n)
        ##0 (!irq_pin_n && !ctrl_wr.write && !vector_fetch)[*6] |-> st.pending_flag)
        else $error("edge lost");
    a_level_holds: assert property ((st.mode && !ctrl_wr.write && !irq_pin_n)[*6]
        |-> st.pending_flag) else $error("level lost");
    a_ack_clears: assert property (s_high ##0 s_ack ##0 !st.mode |=> !st.pending_flag)
        else $error("ack ignored");
    a_reset_clears: assert property ($past(reset)
        |-> !st.pending_flag && !st.mode && !st.request_mask_bit) else $error("reset");
    a_write_loads: assert property (ctrl_wr.write
        |=> st.request_mask_bit == $past(ctrl_wr.request_mask_bit) && st.mode == $past(ctrl_wr.mode))
        else $error("write lost");
endmodule : extirq_latch_assertions
bind extirq_latch extirq_latch_assertions extirq_latch_assertions_i (.*);

// ==== sim/extirq_latch_tb.sv ====
// self-checking bench for the external pin interrupt latch
`timescale 1ns/10ps
module extirq_latch_tb
    import extirq_pkg::*;
;
    logic clk, reset, pull_low, irq_pin_n, ccm, fetch, req;
    logic bph, bpl;
    logic [15:0] vhi, vlo;
    logic [31:0] seed = 32'h2E41;
    logic [31:0] r;
    logic [1:0] q[$];
    logic [1:0] exp_v;
    extirq_ctrl_wr_type wr;
    extirq_status_type st;
    int fail_count = 0;
    int num_checks = 0;
    extirq_pin_source extirq_pin_source_i (.clk(clk), .pull_low(pull_low), .irq_pin_n(irq_pin_n));
    extirq_latch extirq_latch_i (.clk(clk), .reset(reset), .irq_pin_n(irq_pin_n), .ctrl_wr(wr),
        .ext_int_status_control_reg(st), .condition_code_mask(ccm), .vector_fetch(fetch),
        .irq_request(req), .vector_hi_addr(vhi), .vector_lo_addr(vlo), .branch_if_pin_high(bph),
        .branch_if_pin_low(bpl));
    initial begin
        clk = 1'h0;
        forever #2.5 clk = !clk;
    end
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd
    // oldest note against pending flag and request
    always @(posedge clk) begin
        #1;
        if (q.size() > 0) begin
            exp_v = q.pop_front();
            num_checks++;
            if ({st.pending_flag, req} !== exp_v) begin
                fail_count++;
                $display("wrong value %0t got %b want %b", $time, {st.pending_flag, req}, exp_v);
            end
            num_checks++;
            if (!reset && ({bph, bpl} !== {!pull_low, pull_low}
                || vhi !== EXTIRQ_VECTOR_HI_ADDR || vlo !== EXTIRQ_VECTOR_LO_ADDR)) begin
                fail_count++;
                $display("wrong value %0t pin view or vector", $time);
            end
        end
    end
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic expect_out(input logic [1:0] v);
        q.push_back(v);
        @(negedge clk);
    endtask : expect_out
    task automatic write(input logic a, input logic m, input logic md);
        wr = {1'h1, a, m, md};
        @(negedge clk);
        wr.write = 1'h0;
        @(negedge clk);
    endtask : write
    task automatic pin(input logic low);
        pull_low = low;
        step(6);
    endtask : pin
    task automatic conclude();
        if (fail_count == 0 && num_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : conclude
    initial begin
        reset = 1'h1;
        pull_low = 1'h0;
        ccm = 1'h0;
        fetch = 1'h0;
        wr = '0;
        step(16);
        reset = 1'h0;
        pin(1'h1);
        expect_out(2'b11);
        write(1'h1, 1'h0, 1'h0);
        expect_out(2'b00);
        pin(1'h0);
        pin(1'h1);
        expect_out(2'b11);
        pin(1'h0);
        fetch = 1'h1;
        step(1);
        fetch = 1'h0;
        expect_out(2'b00);
        for (int i = 0; i < 8; i++) begin
            r = rnd();
            ccm = r[0];
            write(1'h0, r[1], 1'h0);
            pin(1'h0);
            pin(1'h1);
            expect_out({1'h1, !r[0] && !r[1]});
            write(1'h1, 1'h0, 1'h0);
        end
        ccm = 1'h0;
        write(1'h0, 1'h0, 1'h1);
        step(6);
        expect_out(2'b11);
        write(1'h1, 1'h0, 1'h1);
        expect_out(2'b11);
        pin(1'h0);
        expect_out(2'b00);
        pin(1'h1);
        pin(1'h0);
        expect_out(2'b11);
        write(1'h1, 1'h0, 1'h1);
        expect_out(2'b00);
        pin(1'h1);
        reset = 1'h1;
        step(2);
        expect_out(2'b00);
        reset = 1'h0;
        step(8);
        expect_out(2'b00);
        conclude();
    end
endmodule : extirq_latch_tb

// ==== sim/extirq_pin_source.sv ====
// pin driver standing in for the external interrupt source
`timescale 1ns/10ps
module extirq_pin_source (
    // bench control and pin, pulled up when released
    input wire logic clk,
    input wire logic pull_low,
    output logic irq_pin_n
);
    initial irq_pin_n = 1'h1;
    always @(posedge clk) irq_pin_n <= !pull_low;
endmodule : extirq_pin_source
